/* hdl/ibs_pkg.sv */
package ibs_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [29:0] IDX_STATUS  = 30'h0ffff342;
  localparam logic [29:0] IDX_CONTROL = 30'h0ffff343;
  localparam logic [29:0] IDX_OWNADDR = 30'h0ffff344;
  localparam logic [29:0] IDX_IRQSTAT = 30'h0ffff345;
  localparam logic [29:0] IDX_IRQMASK = 30'h0ffff346;
  // Reset values.
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  // Status bit positions.
  localparam int B_MST = 7;
  localparam int B_ALD = 6;
  localparam int B_EXC = 5;
  localparam int B_COI = 4;
  localparam int B_TRC = 3;
  localparam int B_ACK = 2;
  localparam int B_STD = 1;
  localparam int B_SPD = 0;
  // Control bit positions.
  localparam int B_WREL = 5;
  localparam int B_LREL = 6;
  localparam int B_IEN  = 7;
  // Interrupt event bit positions.
  localparam int E_START = 0;
  localparam int E_STOP  = 1;
  localparam int E_ARB   = 2;
  localparam int E_MATCH = 3;
  localparam int E_EXT   = 4;
  localparam int N_EVT   = 5;
  // Serial clock counts within a byte.
  localparam logic [3:0] CNT_ADDR = 4'h8;
  localparam logic [3:0] CNT_ACK  = 4'h9;
  // Extension code patterns of the upper nibble.
  localparam logic [3:0] EXT_LO = 4'h0;
  localparam logic [3:0] EXT_HI = 4'hf;
  // Bus responses.
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : ibs_pkg

/* hdl/ibs_status.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Status byte is read-only, byte or bit reads
// - Reset clears status; fixed bit layout seven to zero
// - Master flag sets on generated start
// - Master flag clears: stop, loss, release, disable
// - Arbitration loss sets lost flag, clears master
// - Lost flag clears on status read, disable
// - Lost flag clears on foreign bit instruction
// - Extension flag sets on nibble 0000 or 1111
// - Extension flag clears: start, stop, release, disable
// - Match flag sets when address equals own
// - Match flag clears: start, stop, release, disable
// - Transmit flag drives data from output latch
// - Receive status leaves data line floating
// - Master start sets transmit flag
// - Slave sets transmit flag on read bit
// - Transmit flag clear events including slave start
// - Release bit six, enable bit seven, control
// - Wait release at ninth clock clears transmit
module ibs_status
  import ibs_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write channels.
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial bus pins.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_n,
  // Companion controller logic.
  input  wire logic        start_gen,
  input  wire logic        arb_loss,
  input  wire logic        so_latch,
  input  wire logic        bit_op_other,
  // Interrupt.
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True when a word address selects the given register index.
  function automatic logic hit(input logic [31:0] a, input logic [29:0] idx);
    hit = (a[31:2] == idx);
  endfunction : hit

  // Takes the level once the two oldest samples agree, else holds the current level.
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction : filt

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [2:0]       scl_sync_q;      // Serial clock synchroniser chain.
  logic [2:0]       sda_sync_q;      // Serial data synchroniser chain.
  logic             scl_q;           // Filtered serial clock.
  logic             sda_q;           // Filtered serial data.
  logic             scl_d;           // Next filtered serial clock.
  logic             sda_d;           // Next filtered serial data.
  logic [7:0]       status_q;        // Bus status byte.
  logic [7:0]       ctrl_q;          // Bus control byte.
  logic [7:0]       own_q;           // Own slave address.
  logic [N_EVT-1:0] ev_stat_q;       // Sticky event bits.
  logic [N_EVT-1:0] ev_mask_q;       // Event enable mask.
  logic [3:0]       bit_cnt_q;       // Serial clocks seen in this byte.
  logic [7:0]       shift_q;         // Received bits.
  logic             first_byte_q;    // Address byte in progress.
  logic             drive_ok_q;      // First ninth clock has fallen.
  logic             aw_held_q;       // Write address taken.
  logic             w_held_q;        // Write data taken.
  logic [31:0]      aw_addr_q;       // Held write address.
  logic [31:0]      w_data_q;        // Held write data.
  logic             w_lane0_q;       // Held strobe of the low byte.
  logic             scl_rise;        // Serial clock rising edge.
  logic             scl_fall;        // Serial clock falling edge.
  logic             start_det;       // Start condition on the bus.
  logic             stop_det;        // Stop condition on the bus.
  logic             wr_fire;         // Write performed this cycle.
  logic             wr_ctrl;         // Write to the control byte.
  logic             lrel_wr;         // Release bus written with one.
  logic             wrel_wr;         // Wait release written with one.
  logic             ien_fall;        // Interface enable drops.
  logic             rd_fire;         // Read address taken.
  logic             rd_status;       // Status byte read taken.
  logic             common_clr;      // Clear shared by most flags.
  logic             addr_edge;       // Eighth rising edge, address byte.
  logic [7:0]       addr_byte;       // Address byte with its last bit.
  logic [N_EVT-1:0] ev_set;          // Events raised this cycle.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filtered levels.

  // Three flops per pin; a level is taken once stages two and three agree.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      scl_q      <= scl_d;
      sda_q      <= sda_d;
    end
  end

  // Only the second and third stages feed the filter.
  always_comb begin
    scl_d = filt(scl_sync_q, scl_q);
    sda_d = filt(sda_sync_q, sda_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events.

  // Conditions are ignored while the interface is disabled.
  always_comb begin
    scl_rise  = ctrl_q[B_IEN] & scl_d & ~scl_q;
    scl_fall  = ctrl_q[B_IEN] & ~scl_d & scl_q;
    start_det = ctrl_q[B_IEN] & scl_q & scl_d & sda_q & ~sda_d;
    stop_det  = ctrl_q[B_IEN] & scl_q & scl_d & ~sda_q & sda_d;
    addr_byte = {shift_q[6:0], sda_q};
    addr_edge = scl_rise & first_byte_q & (bit_cnt_q == CNT_ADDR - 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing.

  // Counts serial clocks, shifts data, and tracks the address byte.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q    <= 4'h0;
      shift_q      <= RST_BYTE;
      first_byte_q <= 1'b0;
      drive_ok_q   <= 1'b0;
    end else if (start_det || stop_det || common_clr) begin
      // A condition or a release restarts framing.
      bit_cnt_q    <= 4'h0;
      first_byte_q <= start_det;
      drive_ok_q   <= 1'b0;
    end else begin
      if (scl_rise) begin
        // The clock after the ninth begins a new byte.
        bit_cnt_q <= (bit_cnt_q == CNT_ACK) ? 4'h1 : bit_cnt_q + 4'h1;
        shift_q   <= {shift_q[6:0], sda_q};
        if (bit_cnt_q == CNT_ACK) begin
          first_byte_q <= 1'b0;
        end
      end
      if (scl_fall && first_byte_q && bit_cnt_q == CNT_ACK) begin
        drive_ok_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control writes.

  // Decodes one-shot effects of a control write.
  always_comb begin
    wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
    wr_ctrl  = wr_fire & w_lane0_q & hit(aw_addr_q, IDX_CONTROL);
    lrel_wr  = wr_ctrl & w_data_q[B_LREL];
    wrel_wr  = wr_ctrl & w_data_q[B_WREL];
    ien_fall = wr_ctrl & ctrl_q[B_IEN] & ~w_data_q[B_IEN];
    common_clr = lrel_wr | ien_fall;
  end

  // Control holds only the enable; release bits act once and read zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= RST_BYTE;
      own_q  <= RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {w_data_q[B_IEN], 7'h00};
      end
      if (wr_fire && w_lane0_q && hit(aw_addr_q, IDX_OWNADDR)) begin
        own_q <= w_data_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  // Master status and arbitration loss.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q[B_MST] <= 1'b0;
      status_q[B_ALD] <= 1'b0;
    end else begin
      if (stop_det || arb_loss || common_clr) begin
        status_q[B_MST] <= 1'b0;
      end else if (start_gen) begin
        status_q[B_MST] <= 1'b1;
      end
      // A new loss wins over a read or foreign bit clear.
      if (arb_loss) begin
        status_q[B_ALD] <= 1'b1;
      end else if (rd_status || bit_op_other || ien_fall) begin
        status_q[B_ALD] <= 1'b0;
      end
    end
  end

  // Extension code and address match, judged at the eighth rising edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q[B_EXC] <= 1'b0;
      status_q[B_COI] <= 1'b0;
    end else if (start_det || stop_det || common_clr) begin
      status_q[B_EXC] <= 1'b0;
      status_q[B_COI] <= 1'b0;
    end else if (addr_edge) begin
      status_q[B_EXC] <= (addr_byte[7:4] == EXT_LO) |
                         (addr_byte[7:4] == EXT_HI);
      status_q[B_COI] <= (addr_byte[7:1] == own_q[7:1]);
    end
  end

  // Transmit direction flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q[B_TRC] <= 1'b0;
    end else if (stop_det || common_clr || arb_loss) begin
      status_q[B_TRC] <= 1'b0;
    end else if (wrel_wr && bit_cnt_q == CNT_ACK) begin
      status_q[B_TRC] <= 1'b0;
    end else if (start_gen) begin
      status_q[B_TRC] <= 1'b1;
    end else if (start_det && !status_q[B_MST]) begin
      status_q[B_TRC] <= 1'b0;
    end else if (addr_edge) begin
      // Master reading turns to receive; addressed slave sent a read.
      if (status_q[B_MST]) begin
        status_q[B_TRC] <= status_q[B_TRC] & ~sda_q;
      end else begin
        status_q[B_TRC] <= sda_q & (addr_byte[7:1] == own_q[7:1]);
      end
    end
  end

  // Acknowledge, start and stop seen flags.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q[B_ACK] <= 1'b0;
      status_q[B_STD] <= 1'b0;
      status_q[B_SPD] <= 1'b0;
    end else begin
      if (stop_det || common_clr || (scl_rise && bit_cnt_q == CNT_ACK)) begin
        status_q[B_ACK] <= 1'b0;
      end else if (scl_rise && bit_cnt_q == CNT_ACK - 4'h1) begin
        status_q[B_ACK] <= ~sda_q;
      end
      if (start_det) begin
        status_q[B_STD] <= 1'b1;
      end else if (stop_det || common_clr ||
                   (scl_rise && first_byte_q && bit_cnt_q == CNT_ACK)) begin
        status_q[B_STD] <= 1'b0;
      end
      if (stop_det) begin
        status_q[B_SPD] <= 1'b1;
      end else if (ien_fall || (scl_rise && bit_cnt_q == 4'h0 && first_byte_q)) begin
        status_q[B_SPD] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive.

  // Drives the output latch while transmitting, once past the first ninth fall or as master.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o    <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      sda_o    <= so_latch;
      sda_oe_n <= ~(status_q[B_TRC] & (drive_ok_q | status_q[B_MST]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  // Events raised this cycle.
  always_comb begin
    ev_set          = '0;
    ev_set[E_START] = start_det;
    ev_set[E_STOP]  = stop_det;
    ev_set[E_ARB]   = arb_loss;
    ev_set[E_MATCH] = addr_edge & (addr_byte[7:1] == own_q[7:1]);
    ev_set[E_EXT]   = addr_edge & ((addr_byte[7:4] == EXT_LO) |
                                   (addr_byte[7:4] == EXT_HI));
  end

  // Sticky status cleared by writing one; a new event wins over the clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat_q <= '0;
      ev_mask_q <= '0;
      irq       <= 1'b0;
    end else begin
      if (wr_fire && w_lane0_q && hit(aw_addr_q, IDX_IRQSTAT)) begin
        ev_stat_q <= (ev_stat_q & ~w_data_q[N_EVT-1:0]) | ev_set;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set;
      end
      if (wr_fire && w_lane0_q && hit(aw_addr_q, IDX_IRQMASK)) begin
        ev_mask_q <= w_data_q[N_EVT-1:0];
      end
      irq <= |(ev_stat_q & ev_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  // Address and data are taken in either order; response follows both.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        // Status byte is read-only; writes to it are refused.
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(aw_addr_q, IDX_CONTROL) || hit(aw_addr_q, IDX_OWNADDR) ||
                         hit(aw_addr_q, IDX_IRQSTAT) || hit(aw_addr_q, IDX_IRQMASK))
                        ? RESP_OK : RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  // A read of the status byte clears the lost flag.
  always_comb begin
    rd_fire   = s_axi_arvalid & s_axi_arready;
    rd_status = rd_fire & hit(s_axi_araddr, IDX_STATUS);
  end

  // One read at a time; data one cycle after the address is taken.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        if (hit(s_axi_araddr, IDX_STATUS)) begin
          s_axi_rdata <= {24'h000000, status_q};
        end else if (hit(s_axi_araddr, IDX_CONTROL)) begin
          s_axi_rdata <= {24'h000000, ctrl_q};
        end else if (hit(s_axi_araddr, IDX_OWNADDR)) begin
          s_axi_rdata <= {24'h000000, own_q};
        end else if (hit(s_axi_araddr, IDX_IRQSTAT)) begin
          s_axi_rdata <= {27'h0000000, ev_stat_q};
        end else if (hit(s_axi_araddr, IDX_IRQMASK)) begin
          s_axi_rdata <= {27'h0000000, ev_mask_q};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_ERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : ibs_status
`default_nettype wire

/* tb/ibs_status_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Watches bus answers and pin drive of the status block.
module ibs_status_chk
  import ibs_pkg::*;
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Pins and companion strobes.
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        so_latch,
  input wire logic        arb_loss,
  input wire logic        start_gen
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [31:0] ST_ADDR = {IDX_STATUS, 2'b00}; // Status byte address.
  logic                   wr_st_q;                       // Write aimed at status.
  logic                   rd_st_q;                       // Read aimed at status.
  ////////////////////////////////////////////////////////////////////////
  // Remember whether each accepted address named the status word.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_st_q <= 1'b0;
      rd_st_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wr_st_q <= (s_axi_awaddr == ST_ADDR);
      if (s_axi_arvalid && s_axi_arready) rd_st_q <= (s_axi_araddr == ST_ADDR);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  stat_wr_err_a: assert property (s_axi_bvalid && wr_st_q |-> s_axi_bresp == RESP_ERR)
    else $error("status write was not refused");
  stat_rd_ok_a: assert property (s_axi_rvalid && rd_st_q |-> s_axi_rresp == RESP_OK)
    else $error("status read was refused");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_ERR |-> s_axi_rdata == '0)
    else $error("refused read returned data");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  ar_answer_a: assert property (s_axi_arvalid |-> ##[0:3] s_axi_arready)
    else $error("read address not taken in time");
  aw_answer_a: assert property (s_axi_awvalid |-> ##[0:3] s_axi_awready)
    else $error("write address not taken in time");
  sda_copy_a: assert property (!sda_oe_n |-> sda_o == $past(so_latch))
    else $error("driven data is not the output latch");
  arb_float_a: assert property (arb_loss && !start_gen |-> ##[1:3] sda_oe_n)
    else $error("data line still driven after loss");
  start_drive_a: assert property (start_gen && !arb_loss |-> ##[1:3] !sda_oe_n)
    else $error("data line not driven after start");
  // Main scenarios reached.
  cover property (s_axi_bvalid && wr_st_q);
  cover property (!sda_oe_n);
  cover property (arb_loss);
endmodule : ibs_status_chk
bind ibs_status ibs_status_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .so_latch(so_latch), .arb_loss(arb_loss), .start_gen(start_gen));
`default_nettype wire

/* tb/ibs_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Another master on the serial bus; a one on a line releases it.
module ibs_bus_model (
  // Pacing.
  input  wire logic sys_clk,
  input  wire logic slow,
  // Open-drain lines.
  output var  logic scl_rel,
  output var  logic sda_rel
);
  // Both lines rest released at the pull-up.
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // Sets both lines, then holds them for one phase.
  task automatic step(input logic c, input logic d);
    scl_rel <= c;
    sda_rel <= d;
    repeat (slow ? 16 : 8) @(posedge sys_clk);
  endtask : step
  // Data falls while the clock is high.
  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start_cond
  // Eight bits first, then a released ninth clock.
  task automatic send_byte(input logic [7:0] b);
    logic [8:0] f;
    f = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, f[i]);
      step(1'b1, f[i]);
      step(1'b0, f[i]);
    end
  endtask : send_byte
  // Data rises while the clock is high.
  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_cond
endmodule : ibs_bus_model
`default_nettype wire

/* tb/tb_i2c_status_flags.sv */
`timescale 1ns/10ps
`default_nettype none
// Compares two values and counts the outcome.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t: got %h want %h", $time, (a), (b)); end end
module tb_i2c_status_flags;
  import ibs_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0;                      // Clock and reset.
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_d; // Bus words.
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;      // Write requests.
  logic        arvalid = 1'b0, rready = 1'b0;                     // Read requests.
  logic        awready, wready, bvalid, arready, rvalid;          // Bus answers.
  logic [1:0]  bresp, rresp, rsp;                                 // Responses.
  logic        start_gen = 1'b0, arb_loss = 1'b0, bit_op = 1'b0;  // Companion strobes.
  logic        so_latch = 1'b1, slow_bus = 1'b0;                  // Latch bit, pacing.
  logic        sda_o, sda_oe_n, irq, scl_rel, sda_rel;            // Pin side.
  wire         sda_line = sda_rel & (sda_oe_n | sda_o);           // Wired-and line.
  int          n_fail = 0, compares = 0, cyc = 0;                 // Tallies.
  logic [7:0]  f_b [4] = '{8'ha5, 8'ha4, 8'h0e, 8'hf2};           // Address bytes.
  logic [7:0]  f_e [4] = '{8'h18, 8'h10, 8'h20, 8'h20};           // Flags after them.
  ibs_status dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl_rel), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .start_gen(start_gen), .arb_loss(arb_loss), .so_latch(so_latch),
    .bit_op_other(bit_op), .irq(irq));
  ibs_bus_model bus_u (.sys_clk(sys_clk), .slow(slow_bus), .scl_rel(scl_rel), .sda_rel(sda_rel));
  ////////////////////////////////////////////////////////////////////////
  // Prints the tallies and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // One write; both channels are offered together and released when taken.
  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge sys_clk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  // One read; data and response are taken at the answering edge.
  task automatic rd(input logic [29:0] idx);
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    rd_d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd
  // Status flags; the three low detection flags are left out of the compare.
  task automatic stat(input logic [7:0] e);
    rd(IDX_STATUS);
    `CHK(rd_d[7:0] & 8'hf8, e)
  endtask : stat
  // One-cycle strobe on a companion input: 0 start, 1 loss, 2 foreign bit op.
  task automatic pulse(input int k);
    @(posedge sys_clk);
    if (k == 0) start_gen <= 1'b1;
    else if (k == 1) arb_loss <= 1'b1;
    else bit_op <= 1'b1;
    @(posedge sys_clk);
    {start_gen, arb_loss, bit_op} <= 3'h0;
  endtask : pulse
  // Lets the registered interrupt settle, then compares it.
  task automatic irq_is(input logic v);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, v)
  endtask : irq_is
  // Sends one address byte, checks flags, ends by stop, odd frames after a repeated start.
  task automatic frame(input int i);
    bus_u.start_cond();
    bus_u.send_byte(f_b[i]);
    stat(f_e[i]);
    if (f_e[i][B_TRC]) begin
      so_latch <= 1'b0;
      stat(f_e[i]);
      `CHK({sda_oe_n, sda_o}, 2'b00)
      so_latch <= 1'b1;
      wr(IDX_CONTROL, 8'ha0);
      stat(8'h10);
      `CHK(sda_oe_n, 1'b1)
    end
    if (i[0]) bus_u.start_cond();
    else bus_u.stop_cond();
    stat(8'h00);
    if (i[0]) bus_u.stop_cond();
  endtask : frame
  ////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling on the run.
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(IDX_STATUS);
    `CHK(rd_d, 32'h0)
    wr(IDX_STATUS, 8'hff);
    `CHK(rsp, RESP_ERR)
    stat(8'h00);
    rd(30'h0ffff347);
    `CHK({rsp, rd_d}, {RESP_ERR, 32'h0})
    wr(IDX_OWNADDR, 8'ha4);
    wr(IDX_IRQMASK, 8'h1f);
    wr(IDX_CONTROL, 8'h80);
    rd(IDX_CONTROL);
    `CHK(rd_d, 32'h80)
    for (int i = 0; i < 4; i++) begin
      slow_bus <= (i == 1);
      frame(i);
    end
    pulse(0);
    stat(8'h88);
    pulse(1);
    stat(8'h40);
    stat(8'h00);
    pulse(0);
    pulse(1);
    pulse(2);
    stat(8'h00);
    pulse(0);
    wr(IDX_CONTROL, 8'hc0);
    stat(8'h00);
    pulse(0);
    bus_u.start_cond();
    bus_u.send_byte(8'h13);
    stat(8'h80);
    bus_u.stop_cond();
    stat(8'h00);
    pulse(0);
    wr(IDX_CONTROL, 8'h00);
    stat(8'h00);
    rd(IDX_IRQSTAT);
    `CHK(rd_d, 32'h1f)
    irq_is(1'b1);
    wr(IDX_IRQMASK, 8'h00);
    irq_is(1'b0);
    wr(IDX_IRQSTAT, 8'h1b);
    rd(IDX_IRQSTAT);
    `CHK(rd_d, 32'h04)
    wr(IDX_IRQMASK, 8'h04);
    irq_is(1'b1);
    wr(IDX_IRQSTAT, 8'h04);
    irq_is(1'b0);
    stop_test();
  end
endmodule : tb_i2c_status_flags
`default_nettype wire
